// *** verilog/adc_trig_pkg.sv ***
// Constants and types for the converter trigger and clock control block
// Notes on behaviour
// - The external start input comes from the port 0 bit 4 pin when the pin select bit is 0, and from the port 1 bit 3 pin when it is 1.
// - Changing the pin select bit moves the external start input to the new pin at once.
// - The conversion clock is the system clock divided by 1, 2, 4 or 8 for divider codes 00, 01, 10 and 11.
// - Trigger type 00 starts on a falling edge, and 01 on a rising edge, of PWM channel 0, 2 or 4 or of the start pin.
// - Trigger type 10 starts at the centre point, and 11 at the end point, of each PWM period.
// - The centre and period-end triggers exist only while the PWM runs center-aligned.
// - The trigger type takes effect only while external triggering is enabled.
// - With external triggering off, only software setting the start bit begins a conversion.
// - With external triggering on, software or the selected external condition begins a conversion.
// - External triggers are ignored while the start/busy bit is 1, until hardware clears it at the end of conversion.
// - The converter circuit is off when the power enable bit is 0 and on when it is 1.
`default_nettype none

package adc_trig_pkg;

	localparam logic [7:0] CTRL_ONE_ADDR  = 8'he1;
	localparam logic [7:0] CTRL_ZERO_ADDR = 8'he4;

	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam logic [7:0] CTRL_ONE_WMASK = 8'h7f;

	localparam int POWER_BIT    = 0;
	localparam int EXT_EN_BIT   = 1;
	localparam int TYPE_LSB     = 2;
	localparam int TYPE_MSB     = 3;
	localparam int DIV_LSB      = 4;
	localparam int DIV_MSB      = 5;
	localparam int PIN_SEL_BIT  = 6;
	localparam int SRC_LSB      = 0;
	localparam int SRC_MSB      = 1;
	localparam int BUSY_BIT     = 7;

	localparam logic [1:0] SRC_SEL_RESET = 2'h0;

	// Input vector order into the synchroniser
	localparam int IN_PIN_P04 = 0;
	localparam int IN_PIN_P13 = 1;
	localparam int IN_PWM0    = 2;
	localparam int IN_PWM2    = 3;
	localparam int IN_PWM4    = 4;
	localparam int IN_COUNT   = 5;

	typedef enum logic [1:0] {
		TRIG_FALL   = 2'b00,
		TRIG_RISE   = 2'b01,
		TRIG_CENTER = 2'b10,
		TRIG_END    = 2'b11
	} trig_type_t;

	typedef enum logic [1:0] {
		SRC_PWM0 = 2'b00,
		SRC_PWM2 = 2'b01,
		SRC_PWM4 = 2'b10,
		SRC_PIN  = 2'b11
	} src_sel_t;

	typedef struct packed {
		logic [7:0]          ctrl_one;
		logic [1:0]          src_sel;
		logic                busy;
		logic [IN_COUNT-1:0] sync_a;
		logic [IN_COUNT-1:0] sync_b;
		logic [IN_COUNT-1:0] prev;
		logic [2:0]          div_cnt;
		logic                conv_tick;
		logic                start_pulse;
		logic [7:0]          rdata;
	} state_t;

	localparam state_t STATE_RESET = '{
		ctrl_one:    CTRL_ONE_RESET,
		src_sel:     SRC_SEL_RESET,
		busy:        1'b0,
		sync_a:      5'h00,
		sync_b:      5'h00,
		prev:        5'h00,
		div_cnt:     3'h0,
		conv_tick:   1'b0,
		start_pulse: 1'b0,
		rdata:       8'h00
	};

endpackage

`default_nettype wire

// *** verilog/adc_trigger_clock_control.sv ***
// Converter power, conversion clock divider and conversion trigger selection
`default_nettype none

module adc_trigger_clock_control (
	input  wire logic       clk,                // System clock
	input  wire logic       rst,                // Synchronous reset, high
	input  wire logic [7:0] reg_addr,           // Register address
	input  wire logic [7:0] reg_wdata,          // Register write data
	input  wire logic       reg_wr,             // Write strobe
	input  wire logic       reg_rd,             // Read strobe
	output logic      [7:0] reg_rdata,          // Read data, cycle after strobe
	input  wire logic       start_pin_p04,      // Start pin on port 0 bit 4
	input  wire logic       start_pin_p13,      // Start pin on port 1 bit 3
	input  wire logic       pwm_ch0,            // PWM channel 0 output
	input  wire logic       pwm_ch2,            // PWM channel 2 output
	input  wire logic       pwm_ch4,            // PWM channel 4 output
	input  wire logic       pwm_center_aligned, // PWM runs center-aligned
	input  wire logic       pwm_center_event,   // Centre point pulse
	input  wire logic       pwm_period_end,     // Period end pulse
	input  wire logic       conversion_done,    // End of conversion pulse
	output logic            converter_power,    // Converter circuit on
	output logic            conv_clk_tick,      // Conversion clock enable
	output logic            conversion_start,   // Start pulse to converter
	output logic            conversion_busy     // Start/busy bit
);
	import adc_trig_pkg::*;

	state_t s;
	state_t next_s;

	function automatic logic [2:0] div_limit(input logic [1:0] code);
		div_limit = 3'((4'h1 << code) - 4'h1);
	endfunction

	// Edges are taken per input before the mux, so a pin swap makes no false edge
	function automatic logic pick_edge(input logic [IN_COUNT-1:0] edges,
		input logic [1:0] src, input logic pin_sel);
		logic r;
		r = 1'b0;
		unique case (src_sel_t'(src))
			SRC_PWM0: r = edges[IN_PWM0];
			SRC_PWM2: r = edges[IN_PWM2];
			SRC_PWM4: r = edges[IN_PWM4];
			SRC_PIN:  r = pin_sel ? edges[IN_PIN_P13] : edges[IN_PIN_P04];
		endcase
		pick_edge = r;
	endfunction

	logic [IN_COUNT-1:0] raw_in;
	logic [IN_COUNT-1:0] rise;
	logic [IN_COUNT-1:0] fall;
	logic                ext_event;
	logic                ext_accept;
	logic                sw_start;
	logic                start_go;
	trig_type_t          trig_type;

	assign raw_in = {pwm_ch4, pwm_ch2, pwm_ch0, start_pin_p13, start_pin_p04};

	always_comb begin
		next_s = s;
		// Two stages of synchroniser, third stage only for edge compare
		next_s.sync_a = raw_in;
		next_s.sync_b = s.sync_a;
		next_s.prev = s.sync_b;
		rise = s.sync_b & ~s.prev;
		fall = ~s.sync_b & s.prev;

		trig_type = trig_type_t'(s.ctrl_one[TYPE_MSB:TYPE_LSB]);
		ext_event = 1'b0;
		unique case (trig_type)
			TRIG_FALL:   ext_event = pick_edge(fall, s.src_sel, s.ctrl_one[PIN_SEL_BIT]);
			TRIG_RISE:   ext_event = pick_edge(rise, s.src_sel, s.ctrl_one[PIN_SEL_BIT]);
			TRIG_CENTER: ext_event = pwm_center_event & pwm_center_aligned;
			TRIG_END:    ext_event = pwm_period_end & pwm_center_aligned;
		endcase

		ext_accept = s.ctrl_one[EXT_EN_BIT] & ext_event & ~s.busy;
		sw_start = reg_wr && (reg_addr == CTRL_ZERO_ADDR) && reg_wdata[BUSY_BIT];

		// Writing the start bit while busy is dropped, so busy never sticks without a start
		start_go = (sw_start & ~s.busy) | ext_accept;
		next_s.start_pulse = start_go;
		if (conversion_done) begin
			next_s.busy = 1'b0;
		end
		// Set wins over the end-of-conversion clear
		if (start_go) begin
			next_s.busy = 1'b1;
		end

		if (reg_wr && (reg_addr == CTRL_ONE_ADDR)) begin
			next_s.ctrl_one = reg_wdata & CTRL_ONE_WMASK;
		end
		if (reg_wr && (reg_addr == CTRL_ZERO_ADDR)) begin
			next_s.src_sel = reg_wdata[SRC_MSB:SRC_LSB];
		end

		next_s.rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == CTRL_ONE_ADDR) begin
				next_s.rdata = s.ctrl_one;
			end else if (reg_addr == CTRL_ZERO_ADDR) begin
				next_s.rdata = {s.busy, 5'h00, s.src_sel};
			end
		end

		// Divider idles at zero while the converter is off
		if (!s.ctrl_one[POWER_BIT]) begin
			next_s.div_cnt = 3'h0;
			next_s.conv_tick = 1'b0;
		end else if (s.div_cnt >= div_limit(s.ctrl_one[DIV_MSB:DIV_LSB])) begin
			next_s.div_cnt = 3'h0;
			next_s.conv_tick = 1'b1;
		end else begin
			next_s.div_cnt = s.div_cnt + 3'h1;
			next_s.conv_tick = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign converter_power = s.ctrl_one[POWER_BIT];
	assign conv_clk_tick = s.conv_tick;
	assign conversion_start = s.start_pulse;
	assign conversion_busy = s.busy;

endmodule // adc_trigger_clock_control

`default_nettype wire

// *** verif/adc_trig_checker.sv ***
// Port assertions for the converter trigger and clock block
`default_nettype none
module adc_trig_checker (
	input wire logic       clk,              // Clock
	input wire logic       rst,              // Reset
	input wire logic [7:0] reg_addr,         // Address
	input wire logic [7:0] reg_wdata,        // Data
	input wire logic       reg_wr,           // Write
	input wire logic       conversion_done,  // Done
	input wire logic       converter_power,  // Power
	input wire logic       conv_clk_tick,    // Tick
	input wire logic       conversion_start, // Start
	input wire logic       conversion_busy   // Busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctrl;
	wire logic  sw_go = reg_wr && reg_addr == 8'he4 && reg_wdata[7];
	always_ff @(posedge clk) begin
		if (rst || (reg_wr && reg_addr == 8'he1)) ctrl <= rst ? 8'h00 : reg_wdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_power_bit: assert property (reg_wr && reg_addr == 8'he1
		|=> converter_power == $past(reg_wdata[0])) else $error("power bit");
	chk_tick_off: assert property (!converter_power [*2] |-> !conv_clk_tick)
		else $error("tick while off");
	chk_tick_full: assert property ((converter_power && ctrl[5:4] == 2'h0) [*2]
		|-> conv_clk_tick) else $error("tick missing at full rate");
	chk_start_once: assert property (conversion_start |=> !conversion_start)
		else $error("long start");
	chk_start_busy: assert property (conversion_start |-> conversion_busy)
		else $error("start without busy");
	chk_busy_refuse: assert property (conversion_start |-> !$past(conversion_busy))
		else $error("start while busy");
	chk_sw_start: assert property (sw_go && !conversion_busy |=> conversion_start)
		else $error("soft start lost");
	chk_done_clear: assert property (conversion_done && !sw_go |=> !conversion_busy)
		else $error("busy stuck");
	// Enable gates the accept, so only the cycle before the start counts
	chk_ext_gate: assert property (conversion_start
		|-> $past(sw_go) || $past(ctrl[1])) else $error("stray start");
endmodule // adc_trig_checker
bind adc_trigger_clock_control adc_trig_checker i_chk (.clk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .conversion_done, .converter_power, .conv_clk_tick, .conversion_start,
	.conversion_busy);
`default_nettype wire

// *** verif/pwm_far_model.sv ***
// Behavioural PWM generator on the far side of the trigger block
`default_nettype none
module pwm_far_model (
	input  wire logic clk,                // Clock
	input  wire logic rst,                // Reset
	input  wire logic center_mode,        // Run center-aligned
	output logic      pwm_ch0,            // Channel 0
	output logic      pwm_ch2,            // Channel 2
	output logic      pwm_ch4,            // Channel 4
	output logic      pwm_center_aligned, // Type level
	output logic      pwm_center_event,   // Centre pulse
	output logic      pwm_period_end      // End pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt;
	always_ff @(posedge clk) cnt <= rst ? 5'h00 : cnt + 5'h01;
	assign pwm_ch0 = cnt[4];
	assign pwm_ch2 = cnt[3];
	assign pwm_ch4 = cnt[2];
	assign pwm_center_aligned = center_mode;
	// Events come in every type: gating them is the block's job
	assign pwm_center_event = cnt == 5'h0f;
	assign pwm_period_end = cnt == 5'h1f;
endmodule // pwm_far_model
`default_nettype wire

// *** verif/adc_trigger_clock_control_tb.sv ***
// Self-checking bench for the converter trigger and clock block
`default_nettype none
module adc_trigger_clock_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, center_mode = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic        start_pin_p04 = 1'b0, start_pin_p13 = 1'b0, conversion_done = 1'b0;
	logic        converter_power, conv_clk_tick, conversion_start, conversion_busy;
	logic        pwm_ch0, pwm_ch2, pwm_ch4, pwm_center_aligned, pwm_center_event, pwm_period_end;
	int          n_fail = 0, checked = 0, n_start = 0, n_tick = 0, k;
	// Entry: [12] centre mode, [11:10] pin toggles, [9:8] source, [7:0] control one
	logic [13:0] tbl [11] = '{14'h0003, 14'h0107, 14'h0207, 14'h100b, 14'h100f, 14'h000b,
		14'h000f, 14'h1005, 14'h0703, 14'h0b03, 14'h0b43};
	always #4 clk = ~clk;
	adc_trigger_clock_control i_dut (.*);
	pwm_far_model i_pwm (.*);
	always @(posedge clk) begin
		n_start <= n_start + int'(conversion_start);
		n_tick <= n_tick + int'(conv_clk_tick);
		conversion_done <= conversion_busy && !conversion_done && ($urandom % 6 == 0);
	end
	function automatic logic [7:0] any_start(logic [13:0] t);
		if (!t[1]) return 8'h00;
		if (t[3]) return {7'h0, t[12]};
		if (t[9:8] != 2'h3) return 8'h01;
		return {7'h0, t[6] ? t[11] : t[10]};
	endfunction
	task automatic print_verdict();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk) reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge clk);
	endtask
	task automatic idle();
		for (int i = 0; i < 300 && conversion_busy !== 1'b0; i++) @(posedge clk);
		if (conversion_busy !== 1'b0) begin
			n_fail++;
			print_verdict();
		end
		@(posedge clk);
	endtask
	initial begin
		void'($urandom(32'hd06a35c5));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'he1, 8'h00);
		rd(8'he0, 8'h00);
		k = $urandom;
		wr(8'he1, k[7:0] | 8'h80);
		rd(8'he1, k[7:0] & 8'h7f);
		for (int c = 0; c < 4; c++) begin
			wr(8'he1, 8'h01 | 8'(c << 4));
			repeat (16) @(posedge clk);
			k = n_tick;
			repeat (64) @(posedge clk);
			chk(8'(n_tick - k), 8'(64 >> c));
		end
		idle();
		k = n_start;
		wr(8'he4, 8'h80);
		idle();
		chk(8'(n_start - k), 8'h01);
		foreach (tbl[j]) begin
			center_mode <= tbl[j][12];
			wr(8'he4, {6'h00, tbl[j][9:8]});
			rd(8'he4, {6'h00, tbl[j][9:8]});
			wr(8'he1, tbl[j][7:0]);
			k = n_start;
			for (int i = 0; i < 200; i++) begin
				start_pin_p04 <= start_pin_p04 ^ (tbl[j][10] && i % 8 == 0);
				start_pin_p13 <= start_pin_p13 ^ (tbl[j][11] && i % 8 == 0);
				@(posedge clk);
			end
			chk(8'(n_start - k != 0), any_start(tbl[j]));
			wr(8'he1, 8'h01);
			idle();
		end
		print_verdict();
	end
endmodule // adc_trigger_clock_control_tb
`default_nettype wire
